// >>> rtl/dops_pkg.sv
package dops_pkg;

  // ****************************************************************
  // Register map, word offsets
  // ****************************************************************
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_SEL     = 4'h1;
  localparam logic [3:0] REG_FANDLY  = 4'h2;
  localparam logic [3:0] REG_CARDLY  = 4'h3;
  localparam logic [3:0] REG_AMBIENT = 4'h4;
  localparam logic [3:0] REG_RATED   = 4'h5;
  localparam logic [3:0] REG_DOFUNC  = 4'h6;
  localparam logic [3:0] REG_STATUS  = 4'h7;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_FRST = 0;
  localparam int CTRL_PM   = 1;
  localparam int CTRL_INIT = 2;
  localparam logic [11:0] SEL_RESET      = 12'h475;
  localparam logic [8:0]  FANDLY_RESET   = 9'h03C;
  localparam logic [8:0]  FANDLY_MAX     = 9'h12C;
  localparam logic [7:0]  CARDLY_RESET   = 8'h32;
  localparam logic [7:0]  AMBIENT_RESET  = 8'h28;
  localparam logic [7:0]  DO_ALARM_CODE  = 8'h10;
  localparam logic [7:0]  DO_FAULT_CODE  = 8'h0E;

  // ****************************************************************
  // Thresholds in percent of rated current, frequency in 0.1 Hz
  // ****************************************************************
  localparam logic [7:0]  PCT_PHASE_LOST = 8'h05;
  localparam logic [7:0]  PCT_CAR_LOW    = 8'h64;
  localparam logic [7:0]  PCT_CAR_HIGH   = 8'h70;
  localparam logic [7:0]  PCT_CAR_HYST   = 8'h0C;
  localparam logic [7:0]  PCT_HIGH_ALARM = 8'h96;
  localparam logic [7:0]  PCT_SOFT_LIMIT = 8'hA0;
  localparam logic [7:0]  PCT_OVERCUR    = 8'hC8;
  localparam logic [7:0]  PCT_OL_BASE    = 8'h96;
  localparam logic [7:0]  PCT_OL_SIDE    = 8'h8C;
  localparam logic [7:0]  PCT_OL_SLOW    = 8'h1E;
  localparam logic [15:0] FREQ_LOW       = 16'h003C;
  localparam logic [15:0] FREQ_HIGH      = 16'h0046;
  localparam logic [7:0]  AMB_LIMIT      = 8'h28;
  localparam logic [7:0]  AMB_LIMIT_SIDE = 8'h1E;
  localparam logic [7:0]  DERATE_STEP    = 8'h02;

  // ****************************************************************
  // Timing: 10 ms tick from the 10 MHz clock, 100 ticks a second
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [6:0] TICKS_PER_S = 7'h64;

  typedef enum logic [1:0] {
    CAR_NORMAL  = 2'b01,
    CAR_REDUCED = 2'b10
  } dops_car_t;

endpackage : dops_pkg

// >>> rtl/dops_supervisor.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
module dops_supervisor #(
  parameter int          CUR_W       = 12,
  parameter int          TICK_CYCLES = dops_pkg::TICK_CYCLES,
  parameter logic [15:0] RATED_INIT  = 16'h0100,
  parameter logic [1:0]  INSTALL_INIT = 2'h0,
  parameter logic [1:0]  CARMODE_INIT = 2'h1
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [3:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [31:0]      regRdata,
  input  wire logic             runCmd,
  input  wire logic             sampleValid,
  input  wire logic [CUR_W-1:0] phaseCurrentU,
  input  wire logic [CUR_W-1:0] phaseCurrentV,
  input  wire logic [CUR_W-1:0] phaseCurrentW,
  input  wire logic [15:0]      outputFreq,
  input  wire logic             groundLeakDetect,
  input  wire logic             imbalanceDetect,
  output logic                  outputOff,
  output logic                  voltageReduce,
  output logic                  fanOn,
  output logic                  carrierReduce,
  output logic      [7:0]       overloadLevel,
  output logic      [2:0]       digitalOut
);
  import dops_pkg::*;

  // ****************************************************************
  // Settings registers
  // ****************************************************************
  logic [11:0] sel;
  logic [8:0]  fanOffDelay;
  logic [7:0]  carrierRestoreDelay;
  logic [7:0]  ambientTempSetting;
  logic [15:0] ratedCurrent;
  logic [23:0] digitalOutputFunctionSelect;
  logic        pmOlv;
  logic [1:0]  installMethodSelect;

  // Faults and alarm state.
  logic outputPhaseLossFault;
  logic groundLeakFault;
  logic currentImbalanceFault;
  logic overcurrentTrip;
  logic highCurrentAlarm;

  // Field views of the select register.
  wire [1:0] phaseLossSelect        = sel[1:0];
  wire       groundCheckSelect      = sel[2];
  wire       fanModeSelect          = sel[3];
  wire       lowSpeedDerateSelect   = sel[4];
  wire       softLimitSelect        = sel[5];
  wire       imbalanceCheckSelect   = sel[6];
  wire [1:0] carrierReduceMode      = sel[10:9];
  wire       highCurrentAlarmSelect = sel[11];

  // Decoded write strobes.
  wire wrCtrl    = regWr && (regAddr == REG_CTRL);
  wire wrSel     = regWr && (regAddr == REG_SEL);
  wire faultRst  = wrCtrl && regWdata[CTRL_FRST];
  wire paramInit = wrCtrl && regWdata[CTRL_INIT];

  // Settings writes; initialization restores defaults but spares install.
  always_ff @(posedge core_clk)
  begin
    if (srst || paramInit)
    begin
      sel                         <= {SEL_RESET[11:9], 2'h0, SEL_RESET[6:0]};
      fanOffDelay                 <= FANDLY_RESET;
      carrierRestoreDelay         <= CARDLY_RESET;
      ambientTempSetting          <= AMBIENT_RESET;
      ratedCurrent                <= RATED_INIT;
      digitalOutputFunctionSelect <= {3{DO_ALARM_CODE}};
    end
    else if (regWr)
    begin
      if (regAddr == REG_SEL)
        sel <= {regWdata[11:9], 2'h0, regWdata[6:0]};
      if (regAddr == REG_FANDLY && regWdata[8:0] <= FANDLY_MAX)
        fanOffDelay <= regWdata[8:0];
      if (regAddr == REG_CARDLY)
        carrierRestoreDelay <= regWdata[7:0];
      if (regAddr == REG_AMBIENT)
        ambientTempSetting <= regWdata[7:0];
      if (regAddr == REG_RATED)
        ratedCurrent <= regWdata[15:0];
      if (regAddr == REG_DOFUNC)
        digitalOutputFunctionSelect <= regWdata[23:0];
    end
  end

  // Mode reset value of the carrier field is a module parameter.
  logic [1:0] carModeOvr;
  logic       carModeSet;

  // Installation method and carrier mode; init clears the carrier mode flag, carModeSet, and its control write also loads pmOlv.
  // install survives initialization
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      installMethodSelect <= INSTALL_INIT;
      carModeOvr          <= CARMODE_INIT;
      carModeSet          <= 1'b0;
      pmOlv               <= 1'b0;
    end
    else
    begin
      if (wrSel)
        installMethodSelect <= regWdata[8:7];
      if (wrSel)
        carModeSet <= 1'b1;
      else if (paramInit)
        carModeSet <= 1'b0;
      if (wrCtrl)
        pmOlv <= regWdata[CTRL_PM];
    end
  end

  wire [1:0] carMode = carModeSet ? carrierReduceMode : carModeOvr;

  // ****************************************************************
  // Pin synchroniser and time base
  // ****************************************************************
  logic runMeta;
  logic runSync;
  logic [31:0] tickCount;
  logic        tick10ms;
  logic [6:0]  secCount;
  logic        tickSec;

  // Run command is a pin, so it passes two flip-flops first.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      runMeta <= 1'b0;
      runSync <= 1'b0;
    end
    else
    begin
      runMeta <= runCmd;
      runSync <= runMeta;
    end
  end

  // Tick divider; the period is a parameter so simulation can shorten it.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tickCount <= 32'h0;
      tick10ms  <= 1'b0;
      secCount  <= 7'h0;
      tickSec   <= 1'b0;
    end
    else
    begin
      tick10ms <= (tickCount == 32'(TICK_CYCLES - 1));
      tickCount <= (tickCount == 32'(TICK_CYCLES - 1)) ? 32'h0
                                                      : tickCount + 32'h1;
      tickSec <= tick10ms && (secCount == TICKS_PER_S - 7'h1);
      if (tick10ms)
        secCount <= (secCount == TICKS_PER_S - 7'h1) ? 7'h0
                                                    : secCount + 7'h1;
    end
  end

  // ****************************************************************
  // Effective rating and percent comparators
  // ****************************************************************
  // ambient derating of rating
  wire [7:0]  ambLimit  = (installMethodSelect == 2'h1) ? AMB_LIMIT_SIDE
                                                        : AMB_LIMIT;
  wire        ambOver   = $signed(ambientTempSetting) > $signed(ambLimit);
  wire [7:0]  ambExcess = ambOver ? 8'(ambientTempSetting - ambLimit)
                                  : 8'h0;
  wire [15:0] deratePct = 16'(ambExcess) * 16'(DERATE_STEP);
  wire [31:0] effRatedX100 = 32'(ratedCurrent) * 32'(16'd100 - deratePct);

  // True when cur is above pct percent of the effective rated current.
  function automatic logic above(input logic [CUR_W-1:0] cur,
                                 input logic [7:0] pct,
                                 input logic [31:0] ref100);
    above = (32'(cur) * 32'd10000) > (ref100 * 32'(pct));
  endfunction : above

  wire [CUR_W-1:0] curMax01 = (phaseCurrentU > phaseCurrentV) ?
                              phaseCurrentU : phaseCurrentV;
  wire [CUR_W-1:0] curMax   = (curMax01 > phaseCurrentW) ?
                              curMax01 : phaseCurrentW;

  logic [2:0] phaseLost;
  logic       curOver100;
  logic       curOver112;
  logic       curUnderLowHyst;
  logic       curUnderHighHyst;
  logic       curOverAlarm;
  logic       curAtSoftLimit;
  logic       curOverTrip;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      phaseLost        <= 3'h0;
      curOver100       <= 1'b0;
      curOver112       <= 1'b0;
      curUnderLowHyst  <= 1'b1;
      curUnderHighHyst <= 1'b1;
      curOverAlarm     <= 1'b0;
      curAtSoftLimit   <= 1'b0;
      curOverTrip      <= 1'b0;
    end
    else if (sampleValid)
    begin
      phaseLost <= {!above(phaseCurrentW, PCT_PHASE_LOST, effRatedX100),
                    !above(phaseCurrentV, PCT_PHASE_LOST, effRatedX100),
                    !above(phaseCurrentU, PCT_PHASE_LOST, effRatedX100)};
      curOver100       <= above(curMax, PCT_CAR_LOW, effRatedX100);
      curOver112       <= above(curMax, PCT_CAR_HIGH, effRatedX100);
      curUnderLowHyst  <= !above(curMax, PCT_CAR_LOW - PCT_CAR_HYST,
                                 effRatedX100);
      curUnderHighHyst <= !above(curMax, PCT_CAR_HIGH - PCT_CAR_HYST,
                                 effRatedX100);
      curOverAlarm     <= above(curMax, PCT_HIGH_ALARM, effRatedX100);
      curAtSoftLimit   <= above(curMax, PCT_SOFT_LIMIT - 8'h1, effRatedX100);
      curOverTrip      <= above(curMax, PCT_OVERCUR, effRatedX100);
    end
  end

  // ****************************************************************
  // Fault detection and latching
  // ****************************************************************
  wire [1:0] lostCount = 2'(phaseLost[0]) + 2'(phaseLost[1])
                       + 2'(phaseLost[2]);
  wire phaseLossCause = runSync &&
       (((phaseLossSelect == 2'h1) && (lostCount >= 2'h1)) ||
        ((phaseLossSelect == 2'h2) && (lostCount >= 2'h2)));
  wire groundCause    = groundCheckSelect && groundLeakDetect;
  wire imbalanceCause = imbalanceCheckSelect && imbalanceDetect;
  wire overcurCause   = !softLimitSelect && curOverTrip;

  // A fault stays set while its cause holds, so a reset then is ignored.
  // latch until reset and clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      outputPhaseLossFault  <= 1'b0;
      groundLeakFault       <= 1'b0;
      currentImbalanceFault <= 1'b0;
      overcurrentTrip       <= 1'b0;
    end
    else
    begin
      outputPhaseLossFault  <= phaseLossCause ||
                               (outputPhaseLossFault && !faultRst);
      groundLeakFault       <= groundCause || (groundLeakFault && !faultRst);
      currentImbalanceFault <= imbalanceCause ||
                               (currentImbalanceFault && !faultRst);
      overcurrentTrip       <= overcurCause || (overcurrentTrip && !faultRst);
    end
  end

  wire anyFault = outputPhaseLossFault || groundLeakFault ||
                  currentImbalanceFault || overcurrentTrip;

  // ****************************************************************
  // Fan timer
  // ****************************************************************
  logic [8:0] fanTimer;

  // Timed mode counts whole seconds; the first second may run short.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fanTimer <= 9'h0;
      fanOn    <= 1'b0;
    end
    else if (fanModeSelect)
    begin
      fanTimer <= 9'h0;
      fanOn    <= 1'b1;
    end
    else if (runSync)
    begin
      fanTimer <= fanOffDelay;
      fanOn    <= 1'b1;
    end
    else if (fanTimer == 9'h0)
      fanOn <= 1'b0;
    else if (tickSec)
      fanTimer <= fanTimer - 9'h1;
  end

  // ****************************************************************
  // Carrier reduction state machine
  // ****************************************************************
  dops_car_t  carState;
  dops_car_t  next_carState;
  logic [7:0] carTimer;

  wire freqLow  = outputFreq < FREQ_LOW;
  wire freqHigh = outputFreq > FREQ_HIGH;
  wire carAllowed = (carMode != 2'h0) && (carrierRestoreDelay != 8'h0)
                    && !pmOlv;
  wire carEnter = (freqLow && curOver100) ||
                  ((carMode == 2'h2) && freqHigh && curOver112);
  wire carCalm = freqLow ? curUnderLowHyst : curUnderHighHyst;
  wire mode1Exit = curUnderLowHyst || freqHigh;

  always_comb
  begin
    next_carState = carState;
    case (carState)
      CAR_NORMAL:
        if (carAllowed && carEnter)
          next_carState = CAR_REDUCED;
      CAR_REDUCED:
        if (!carAllowed)
          next_carState = CAR_NORMAL;
        else if ((carMode == 2'h1) && mode1Exit)
          next_carState = CAR_NORMAL;
        else if ((carMode == 2'h2) && carCalm && (carTimer == 8'h0))
          next_carState = CAR_NORMAL;
      default:
        next_carState = CAR_NORMAL;
    endcase
  end

  // Restore timer restarts whenever current is not yet calm.
  // restore off delay
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      carState <= CAR_NORMAL;
      carTimer <= 8'h0;
    end
    else
    begin
      carState <= next_carState;
      if (!carCalm || carState == CAR_NORMAL)
        carTimer <= carrierRestoreDelay;
      else if (tick10ms && carTimer != 8'h0)
        carTimer <= carTimer - 8'h1;
    end
  end

  // ****************************************************************
  // Output flip-flops
  // ****************************************************************
  // low speed derating
  wire [7:0] olBase = (installMethodSelect == 2'h1) ? PCT_OL_SIDE
                                                    : PCT_OL_BASE;
  wire [7:0] olLevelNext = (lowSpeedDerateSelect && freqLow) ?
                           8'(olBase - PCT_OL_SLOW) : olBase;
  wire alarmNext = highCurrentAlarmSelect && curOverAlarm;

  logic [2:0] doNext;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_do
      wire [7:0] func = digitalOutputFunctionSelect[gi*8 +: 8];
      assign doNext[gi] = ((func == DO_ALARM_CODE) && highCurrentAlarm) ||
                          ((func == DO_FAULT_CODE) && anyFault);
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      outputOff        <= 1'b0;
      voltageReduce    <= 1'b0;
      carrierReduce    <= 1'b0;
      overloadLevel    <= PCT_OL_BASE;
      highCurrentAlarm <= 1'b0;
      digitalOut       <= 3'h0;
    end
    else
    begin
      outputOff        <= anyFault;
      voltageReduce    <= softLimitSelect && curAtSoftLimit;
      carrierReduce    <= (next_carState == CAR_REDUCED);
      overloadLevel    <= olLevelNext;
      highCurrentAlarm <= alarmNext;
      digitalOut       <= doNext;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  wire [31:0] statusWord = {18'h0, carState == CAR_REDUCED, fanOn, runSync,
                            lostCount, 3'h0, outputOff, highCurrentAlarm,
                            overcurrentTrip, currentImbalanceFault,
                            groundLeakFault, outputPhaseLossFault};
  logic [31:0] readMux;

  always_comb
  begin
    case (regAddr)
      REG_CTRL:    readMux = {30'h0, pmOlv, 1'b0};
      REG_SEL:     readMux = {20'h0, sel[11:9], installMethodSelect,
                              sel[6:0]};
      REG_FANDLY:  readMux = {23'h0, fanOffDelay};
      REG_CARDLY:  readMux = {24'h0, carrierRestoreDelay};
      REG_AMBIENT: readMux = {24'h0, ambientTempSetting};
      REG_RATED:   readMux = {16'h0, ratedCurrent};
      REG_DOFUNC:  readMux = {8'h0, digitalOutputFunctionSelect};
      REG_STATUS:  readMux = statusWord;
      default:     readMux = 32'h0;
    endcase
  end

  // Read data stands for one cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      regRdata <= 32'h0;
    else
      regRdata <= regRd ? readMux : 32'h0;
  end

endmodule : dops_supervisor

// >>> test/dops_supervisor_checker.sv
`timescale 1ns/100ps
module dops_supervisor_checker
  import dops_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        runCmd,
  input wire logic        groundLeakDetect,
  input wire logic        imbalanceDetect,
  input wire logic        outputOff,
  input wire logic        voltageReduce,
  input wire logic        fanOn,
  input wire logic        carrierReduce
);
  // ****
  // Settings shadow
  // ****
  logic [11:0] sel;
  logic        pm;
  logic [7:0]  carDly;
  logic [7:0]  frstAge;
  wire         ctrlWr = regWr && regAddr == REG_CTRL;
  wire         initWr = ctrlWr && regWdata[CTRL_INIT];
  wire         noCar  = sel[10:9] == 2'h0 || pm || carDly == 8'h00;
  wire   [7:0] next_frstAge = (ctrlWr && regWdata[CTRL_FRST]) ? 8'h00 :
                              frstAge + {7'h00, frstAge != 8'hFF};
  // Init keeps the install field; the age counter saturates.
  always_ff @(posedge core_clk)
  begin
    frstAge <= srst ? 8'hFF : next_frstAge;
    if (srst || initWr)
    begin
      sel    <= {SEL_RESET[11:9], srst ? 2'h0 : sel[8:7], SEL_RESET[6:0]};
      pm     <= 1'b0;
      carDly <= CARDLY_RESET;
    end
    else if (regWr)
    begin
      if (regAddr == REG_SEL) sel <= regWdata[11:0];
      if (ctrlWr) pm <= regWdata[CTRL_PM];
      if (regAddr == REG_CARDLY) carDly <= regWdata[7:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence gndSeen;
    groundLeakDetect && sel[2];
  endsequence
  sequence imbSeen;
    imbalanceDetect && sel[6];
  endsequence
  gnd_trip_a: assert property (gndSeen |-> ##[1:3] outputOff)
    else $error("ground leak left output on");
  imb_trip_a: assert property (imbSeen |-> ##[1:3] outputOff)
    else $error("imbalance left output on");
  fan_always_a: assert property (sel[3] [*3] |-> fanOn)
    else $error("fan off in continuous mode");
  fan_run_a: assert property (runCmd [*5] |-> fanOn)
    else $error("fan off while running");
  no_car_a: assert property (noCar [*3] |-> !carrierReduce)
    else $error("carrier lowered while barred");
  soft_off_a: assert property (!sel[5] [*3] |-> !voltageReduce)
    else $error("voltage cut with limit disabled");
  off_hold_a: assert property (outputOff && groundLeakDetect && sel[2]
    |=> outputOff)
    else $error("output released with cause present");
  clear_only_a: assert property ($fell(outputOff) |-> frstAge <= 8'h04)
    else $error("output released without fault reset");
endmodule : dops_supervisor_checker

bind dops_supervisor dops_supervisor_checker u_dops_supervisor_checker (.*);

// >>> test/dops_motor_model.sv
`timescale 1ns/100ps
module dops_motor_model (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        outputOff,
  input wire logic [11:0] levelU,
  input wire logic [11:0] levelV,
  input wire logic [11:0] levelW,
  input wire logic [15:0] freqSet,
  input wire logic        gndSet,
  input wire logic        imbSet,
  output logic            sampleValid,
  output logic     [11:0] phaseCurrentU,
  output logic     [11:0] phaseCurrentV,
  output logic     [11:0] phaseCurrentW,
  output logic     [15:0] outputFreq,
  output logic            groundLeakDetect,
  output logic            imbalanceDetect
);
  // A shut-off stage coasts, so no current flows. The load is stiff:
  // a voltage cut does not lower the current, a known limitation.
  always_ff @(posedge core_clk)
  begin
    sampleValid      <= !srst && !sampleValid;
    phaseCurrentU    <= outputOff ? 12'h000 : levelU;
    phaseCurrentV    <= outputOff ? 12'h000 : levelV;
    phaseCurrentW    <= outputOff ? 12'h000 : levelW;
    outputFreq       <= outputOff ? 16'h0000 : freqSet;
    groundLeakDetect <= gndSet;
    imbalanceDetect  <= imbSet;
  end
endmodule : dops_motor_model

// >>> test/drive_output_protection_supervisor_tb_top.sv
`timescale 1ns/100ps
module drive_output_protection_supervisor_tb_top;
  import dops_pkg::*;
  logic        core_clk, srst, regWr, regRd, runCmd, gndSet, imbSet;
  logic        sampleValid, groundLeakDetect, imbalanceDetect, outputOff;
  logic        voltageReduce, fanOn, carrierReduce;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdVal;
  logic [11:0] levelU, levelV, levelW, hU, phaseCurrentU;
  logic [11:0] phaseCurrentV, phaseCurrentW;
  logic [15:0] freqSet, outputFreq;
  logic [7:0]  overloadLevel;
  logic [2:0]  digitalOut;
  int          fail_count, samples_checked, exp;
  integer      seed = 32'h4F84B363;
  logic [3:0]  rstAddr [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hF};
  logic [31:0] rstVal [7] = '{32'h475, 32'h3C, 32'h32, 32'h28, 32'h100,
                              32'h101010, 32'h0};
  // A short tick keeps one second at a thousand cycles.
  dops_supervisor #(.TICK_CYCLES(10), .CARMODE_INIT(2'h2))
    u_dops_supervisor (.*);
  dops_motor_model u_dops_motor_model (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    rdVal = regRdata;
  endtask : rd
  task automatic chkReg(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chkReg
  task automatic chkPin(input string nm, input logic [7:0] e, g);
    chkReg(nm, {24'h0, e}, {24'h0, g});
  endtask : chkPin
  task automatic drive(input int u, v, w, f);
    levelU <= 12'(u);
    levelV <= 12'(v);
    levelW <= 12'(w);
    freqSet <= 16'(f);
    tick(12);
  endtask : drive
  // Faults clear only with the causes gone, so stop and drop to half the rated current first.
  task automatic clearFaults;
    runCmd <= 1'b0;
    gndSet <= 1'b0;
    imbSet <= 1'b0;
    drive(128, 128, 128, 300);
    wr(REG_CTRL, 32'h1);
    tick(6);
    chkPin("output released", 0, outputOff);
  endtask : clearFaults
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    tick(100000);
    fail_count++;
    results();
  end
  initial
  begin
    {regWr, regRd, runCmd, gndSet, imbSet, srst} = 6'h01;
    {regAddr, regWdata, levelU, levelV, levelW, freqSet} = '0;
    tick(10);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      rd(rstAddr[i]);
      chkReg("reset value", rstVal[i], rdVal);
    end
    wr(REG_FANDLY, 32'h12C);
    wr(REG_FANDLY, 32'h12D);
    rd(REG_FANDLY);
    chkReg("fan delay", 32'h12C, rdVal);
    // phase loss; 12 is under five percent of 256, 13 is not
    for (int m = 0; m < 3; m++)
      for (int n = 1; n < 3; n++)
      begin
        hU = 12'd13 + 12'($unsigned($random(seed)) % 243);
        wr(REG_SEL, 32'h474 | m);
        runCmd <= 1'b1;
        drive(12, (n == 2) ? 12 : hU, hU, 300);
        exp = (m == 1) || (m == 2 && n == 2);
        chkPin("phase trip", exp[7:0], outputOff);
        rd(REG_STATUS);
        chkReg("phase flag", 32'(exp), {31'h0, rdVal[0]});
        clearFaults();
      end
    for (int e = 0; e < 2; e++)
    begin
      wr(REG_SEL, e ? 32'h475 : 32'h431);
      gndSet <= 1'b1;
      tick(8);
      chkPin("ground trip", 8'(e), outputOff);
      clearFaults();
      imbSet <= 1'b1;
      tick(8);
      chkPin("imbalance trip", 8'(e), outputOff);
      clearFaults();
    end
    $display("fault tests done");
    wr(REG_SEL, 32'h475);
    runCmd <= 1'b1;
    drive(435, 435, 435, 300);
    chkPin("soft limit", 1, voltageReduce);
    drive(384, 384, 384, 300);
    chkPin("soft release", 0, voltageReduce);
    chkPin("high alarm off", 0, digitalOut);
    drive(397, 397, 397, 300);
    chkPin("high alarm off", 0, digitalOut);
    wr(REG_SEL, 32'hC75);
    tick(6);
    chkPin("high alarm", 7, digitalOut);
    wr(REG_DOFUNC, 32'h0E0010);
    tick(6);
    chkPin("alarm output", 1, digitalOut);
    wr(REG_SEL, 32'h455);
    drive(538, 538, 538, 300);
    chkPin("overcurrent", 1, outputOff);
    rd(REG_STATUS);
    chkReg("overcurrent flag", 32'h1, {31'h0, rdVal[3]});
    clearFaults();
    $display("current tests done");
    wr(REG_SEL, 32'h275);
    runCmd <= 1'b1;
    drive(256, 256, 256, 50);
    chkPin("carrier at 100", 0, carrierReduce);
    drive(257, 257, 257, 50);
    chkPin("carrier low", 1, carrierReduce);
    drive(230, 230, 230, 50);
    chkPin("carrier hysteresis", 1, carrierReduce);
    drive(225, 225, 225, 50);
    chkPin("carrier restore", 0, carrierReduce);
    drive(257, 257, 257, 50);
    drive(257, 257, 257, 71);
    chkPin("carrier above 7", 0, carrierReduce);
    wr(REG_SEL, 32'h475);
    drive(286, 286, 286, 100);
    chkPin("carrier at 112", 0, carrierReduce);
    drive(287, 287, 287, 100);
    chkPin("carrier high", 1, carrierReduce);
    drive(250, 250, 250, 100);
    tick(300);
    chkPin("carrier delay", 1, carrierReduce);
    tick(300);
    chkPin("carrier back", 0, carrierReduce);
    wr(REG_SEL, 32'h075);
    drive(300, 300, 300, 50);
    chkPin("carrier mode 0", 0, carrierReduce);
    wr(REG_SEL, 32'h475);
    wr(REG_CARDLY, 32'h0);
    drive(300, 300, 300, 50);
    chkPin("carrier delay 0", 0, carrierReduce);
    wr(REG_CARDLY, 32'h32);
    wr(REG_CTRL, 32'h2);
    drive(300, 300, 300, 50);
    chkPin("carrier pm", 0, carrierReduce);
    wr(REG_CTRL, 32'h0);
    $display("carrier tests done");
    drive(128, 128, 128, 50);
    chkPin("derated level", 8'd120, overloadLevel);
    wr(REG_SEL, 32'h465);
    drive(128, 128, 128, 50);
    chkPin("plain level", 8'd150, overloadLevel);
    wr(REG_AMBIENT, 32'd45);
    drive(128, 128, 128, 300);
    chkPin("ambient level", 8'd150, overloadLevel);
    wr(REG_SEL, 32'h4F5);
    drive(128, 128, 128, 300);
    chkPin("side level", 8'd140, overloadLevel);
    wr(REG_CTRL, 32'h4);
    rd(REG_SEL);
    chkReg("install kept", 32'h4F5, rdVal);
    tick(12);
    chkPin("init level", 8'd140, overloadLevel);
    wr(REG_FANDLY, 32'h2);
    runCmd <= 1'b0;
    tick(900);
    chkPin("fan held", 1, fanOn);
    tick(1200);
    chkPin("fan off", 0, fanOn);
    wr(REG_SEL, 32'h47D);
    tick(5);
    chkPin("fan always", 1, fanOn);
    $display("setting tests done");
    results();
  end
endmodule : drive_output_protection_supervisor_tb_top
